// ===== rtl/vj_pkg.sv
package vj_pkg;
	localparam int NCH      = 4;
	localparam int HIST     = 64;
	localparam int NGRP     = 2;
	localparam int CLK_HZ   = 20000000;
	localparam int TRIP_MS  = 20;
	localparam int TRIP_CYC = CLK_HZ / 1000 * TRIP_MS;

	localparam logic [13:0] THR_MIN = 14'h0005;
	localparam logic [13:0] THR_MAX = 14'h0bb8;
	localparam logic [13:0] THR_RST = 14'h01f4;
	localparam logic [13:0] UV_MIN  = 14'h0001;
	localparam logic [13:0] UV_MAX  = 14'h2710;
	localparam logic [13:0] UV_RST  = 14'h251c;
	localparam logic [15:0] NOM_RST = 16'h4000;
	localparam logic [31:0] PCT_ONE = 32'h00002710;

	localparam logic [17:0] ANG_FULL = 18'h08ca0;
	localparam logic [17:0] ANG_HALF = 18'h04650;
	localparam logic [17:0] ANG_QTR  = 18'h02328;
	localparam logic [31:0] ATAN_LIN = 32'h00001194;
	localparam logic [31:0] ATAN_CRV = 32'h0000061e;

	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_GLOB  = 8'h04;
	localparam logic [7:0] A_NOM   = 8'h08;
	localparam logic [7:0] A_UV    = 8'h0c;
	localparam logic [7:0] A_STAT  = 8'h10;
	localparam logic [7:0] A_CNTA  = 8'h14;
	localparam logic [7:0] A_CNTT  = 8'h18;
	localparam logic [7:0] A_CNTB  = 8'h1c;
	localparam logic [7:0] A_THR   = 8'h20;
	localparam logic [7:0] A_DIFF  = 8'h30;
	localparam logic [7:0] A_RATIO = 8'h40;

	localparam int C_STAGE = 0;
	localparam int C_CHAN  = 4;
	localparam int C_FORCE = 8;
	localparam int C_NODE  = 12;
	localparam int G_FORCE = 0;
	localparam int G_ALLOW = 1;

	typedef enum logic [1:0] {COND_NORMAL, COND_BLOCKED, COND_TRIP, COND_ALARM} cond_t;
	typedef enum logic [2:0] {NODE_ON, NODE_BLOCKED, NODE_TEST, NODE_TEST_BLOCKED,
		NODE_OFF} node_t;
	typedef enum logic [3:0] {SEL_ALL_PP, SEL_ANY_PP, SEL_L12, SEL_L23, SEL_L31,
		SEL_ALL_PE, SEL_ANY_PE, SEL_L1, SEL_L2, SEL_L3, SEL_U4} chan_sel_t;
endpackage

// ===== rtl/chan_if.sv
`timescale 1ns/1ps
interface chan_if;
	logic               smp;
	logic signed [15:0] re;
	logic signed [15:0] im;
	logic        [13:0] thr;
	logic               valid;
	logic signed [16:0] diff;
	logic        [16:0] mag;
	logic        [15:0] ratio;
	modport trk (input smp, re, im, thr, output valid, diff, mag, ratio);
	modport host (output smp, re, im, thr, input valid, diff, mag, ratio);
endinterface

// ===== rtl/angle_track.sv
`timescale 1ns/1ps
module angle_track (
	input wire logic clk_i,   // Sample clock
	input wire logic rst_n_i, // Sync reset, low
	chan_if.trk      c        // Channel phasor and results
);
	typedef struct packed {
		logic [vj_pkg::HIST-1:0][17:0] hist;
		logic [5:0]                    idx;
		logic                          full;
		logic                          valid;
		logic signed [16:0]            diff;
		logic [16:0]                   mag;
		logic [15:0]                   ratio;
	} trk_t;

	trk_t s_reg, s_next;

	// ----------------------------------------
	// Angle estimate and jump
	// ----------------------------------------
	// Polynomial arctangent, about 0.3 degree error; the error mostly cancels
	// in the 64-sample difference since both angles see the same curve.
	always_comb begin
		logic [31:0] ax, ay, mx, mn, q, t;
		logic [17:0] a1, ang;
		logic signed [18:0] d;
		s_next = s_reg;
		ax = c.re[15] ? 32'(-c.re) : 32'(c.re);
		ay = c.im[15] ? 32'(-c.im) : 32'(c.im);
		mx = (ax > ay) ? ax : ay;
		mn = (ax > ay) ? ay : ax;
		q = (mx == 32'h0) ? 32'h0 : (mn << 12) / mx;
		t = (vj_pkg::ATAN_LIN * q + vj_pkg::ATAN_CRV * ((q * (32'h1000 - q)) >> 12)) >> 12;
		a1 = (ay > ax) ? vj_pkg::ANG_QTR - t[17:0] : t[17:0];
		if (!c.re[15] && !c.im[15])
			ang = a1;
		else if (c.re[15] && !c.im[15])
			ang = vj_pkg::ANG_HALF - a1;
		else if (c.re[15])
			ang = vj_pkg::ANG_HALF + a1;
		else
			ang = (a1 == 18'h0) ? 18'h0 : vj_pkg::ANG_FULL - a1;
		d = 19'(ang) - 19'(s_reg.hist[s_reg.idx]);
		// Signed compare, otherwise a small lag wraps into a large lead
		if (d > $signed(19'(vj_pkg::ANG_HALF)))
			d = d - 19'(vj_pkg::ANG_FULL);
		else if (d < -$signed(19'(vj_pkg::ANG_HALF)))
			d = d + 19'(vj_pkg::ANG_FULL);
		if (c.smp) begin
			s_next.hist[s_reg.idx] = ang;
			s_next.idx = s_reg.idx + 6'h01;
			s_next.full = s_reg.full | (s_reg.idx == 6'h3f);
			s_next.valid = s_reg.full;
			s_next.diff = s_reg.full ? d[16:0] : 17'h0;
			s_next.mag = 17'(mx + ((mn * 32'h3) >> 3));
			t = ((d[18] ? 32'(-d) : 32'(d)) * 32'h64) / 32'(c.thr);
			s_next.ratio = (t > 32'hffff) ? 16'hffff : t[15:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign c.valid = s_reg.valid;
	assign c.diff  = s_reg.diff;
	assign c.mag   = s_reg.mag;
	assign c.ratio = s_reg.ratio;

	a_slot_advance: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		c.smp |=> s_reg.idx == 6'($past(s_reg.idx) + 6'h01))
		else $error("history slot did not advance on sample");
	a_jump_wrapped: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$signed(s_reg.diff) <= 17'sh04650 && $signed(s_reg.diff) >= -17'sh04650)
		else $error("angle jump outside half turn");
endmodule

// ===== rtl/vector_jump.sv
`timescale 1ns/1ps
module vector_jump #(
	parameter logic [18:0] TRIP_CYCLES = 19'(vj_pkg::TRIP_CYC) // Trip pulse length
) (
	input  wire logic                  REF_CLK_I,   // 20 MHz clock
	input  wire logic                  RST_N_I,     // Sync reset, low
	input  wire logic                  HSEL_I,      // AHB select
	input  wire logic [31:0]           HADDR_I,     // AHB address
	input  wire logic [1:0]            HTRANS_I,    // AHB transfer type
	input  wire logic                  HWRITE_I,    // AHB write
	input  wire logic [2:0]            HSIZE_I,     // AHB size, word only
	input  wire logic [31:0]           HWDATA_I,    // AHB write data
	input  wire logic                  HREADY_I,    // AHB ready in
	output logic      [31:0]           HRDATA_O,    // AHB read data
	output logic                       HREADYOUT_O, // AHB ready out
	output logic                       HRESP_O,     // AHB response
	input  wire logic                  SAMPLE_I,    // Sample strobe
	input  wire logic [3:0][15:0]      CH_RE_I,     // Phasor real parts
	input  wire logic [3:0][15:0]      CH_IM_I,     // Phasor imaginary parts
	input  wire logic                  BLOCK_I,     // Block input
	input  wire logic                  GROUP_I,     // Active setting group
	output logic                       TRIP_O,      // Trip pulse
	output logic                       ALARM_O,     // Alarm level
	output logic                       BLOCKED_O,   // Blocked level
	output logic      [2:0]            EVT_ON_O,    // On events alarm/trip/block
	output logic      [2:0]            EVT_OFF_O,   // Off events alarm/trip/block
	output logic      [31:0]           EVT_STAMP_O  // Sample count stamp
);
	typedef struct packed {
		logic                            stage;
		vj_pkg::chan_sel_t               chan;
		vj_pkg::cond_t                   frc;
		vj_pkg::node_t                   node;
		logic                            force_en;
		logic                            allow;
		logic [15:0]                     nom;
		logic [13:0]                     uv;
		logic [vj_pkg::NGRP-1:0][13:0]   thr_t;
		logic [vj_pkg::NGRP-1:0][13:0]   thr_a;
		logic                            wr_pend;
		logic [7:0]                      wr_addr;
		logic [31:0]                     rdata;
		logic                            ready;
		logic                            smp_d;
		logic                            blk;
		vj_pkg::cond_t                   cond;
		logic                            uvb;
		logic [18:0]                     tmr;
		logic [2:0]                      lvl;
		logic                            trip;
		logic                            alarm;
		logic [2:0]                      on;
		logic [2:0]                      off;
		logic [15:0]                     cnt_a;
		logic [15:0]                     cnt_t;
		logic [15:0]                     cnt_b;
		logic [31:0]                     stamp;
	} st_t;

	st_t s_reg, s_next;

	chan_if cif[vj_pkg::NCH] ();

	logic [vj_pkg::NCH-1:0]             vld;
	logic [vj_pkg::NCH-1:0][16:0]       dif;
	logic [vj_pkg::NCH-1:0][16:0]       mag;
	logic [vj_pkg::NCH-1:0][15:0]       rat;
	logic [vj_pkg::NCH-1:0]             pt;
	logic [vj_pkg::NCH-1:0]             pa;
	logic [vj_pkg::NCH-1:0]             low;
	logic [vj_pkg::NCH-1:0]             mask;
	logic                               all_req;
	logic                               pick_t;
	logic                               pick_a;
	logic                               uv_any;
	logic [13:0]                        thr_t;
	logic [13:0]                        thr_a;

	// ----------------------------------------
	// Channel trackers
	// ----------------------------------------
	assign thr_t = s_reg.thr_t[GROUP_I];
	assign thr_a = s_reg.thr_a[GROUP_I];

	for (genvar i = 0; i < vj_pkg::NCH; i++) begin : g_ch
		logic [16:0] adif;
		assign cif[i].smp = SAMPLE_I;
		assign cif[i].re  = CH_RE_I[i];
		assign cif[i].im  = CH_IM_I[i];
		assign cif[i].thr = thr_t;
		assign vld[i] = cif[i].valid;
		assign dif[i] = cif[i].diff;
		assign mag[i] = cif[i].mag;
		assign rat[i] = cif[i].ratio;
		assign adif = dif[i][16] ? 17'(-dif[i]) : dif[i];
		assign pt[i] = vld[i] && (adif >= 17'(thr_t));
		assign pa[i] = vld[i] && (adif >= 17'(thr_a));
		assign low[i] = vld[i] && (32'(mag[i]) * vj_pkg::PCT_ONE
			< 32'(s_reg.nom) * 32'(s_reg.uv));
		angle_track u_trk (
			.clk_i   (REF_CLK_I),
			.rst_n_i (RST_N_I),
			.c       (cif[i].trk)
		);
	end

	// ----------------------------------------
	// Monitored voltage selection
	// ----------------------------------------
	// Channels 1..3 carry either the line-to-line or line-to-earth set,
	// so both families map onto the same three trackers.
	always_comb begin
		all_req = 1'b0;
		unique case (s_reg.chan)
			vj_pkg::SEL_ALL_PP, vj_pkg::SEL_ALL_PE: begin
				mask = 4'h7;
				all_req = 1'b1;
			end
			vj_pkg::SEL_ANY_PP, vj_pkg::SEL_ANY_PE: mask = 4'h7;
			vj_pkg::SEL_L12, vj_pkg::SEL_L1:        mask = 4'h1;
			vj_pkg::SEL_L23, vj_pkg::SEL_L2:        mask = 4'h2;
			vj_pkg::SEL_L31, vj_pkg::SEL_L3:        mask = 4'h4;
			vj_pkg::SEL_U4:                         mask = 4'h8;
			default:                                mask = 4'h0;
		endcase
		pick_t = all_req ? (&(pt | ~mask)) : (|(pt & mask));
		pick_a = s_reg.stage && (all_req ? (&(pa | ~mask)) : (|(pa & mask)));
		uv_any = |(low & mask);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic          acc;
		logic [7:0]    ra;
		logic [31:0]   rd;
		vj_pkg::cond_t nc;
		logic [2:0]    nl;
		s_next = s_reg;
		acc = HSEL_I && HTRANS_I[1] && HREADY_I;
		ra = HADDR_I[7:0];
		rd = 32'h0;
		nc = s_reg.cond;
		nl = s_reg.lvl;

		s_next.ready = 1'b1;
		s_next.wr_pend = acc && HWRITE_I;
		s_next.wr_addr = ra;

		// Bus read, captured in the address phase
		if (ra == vj_pkg::A_CTRL)
			rd = {17'h0, s_reg.node, 2'h0, s_reg.frc, s_reg.chan, 3'h0, s_reg.stage};
		else if (ra == vj_pkg::A_GLOB)
			rd = {30'h0, s_reg.allow, s_reg.force_en};
		else if (ra == vj_pkg::A_NOM)
			rd = {16'h0, s_reg.nom};
		else if (ra == vj_pkg::A_UV)
			rd = {18'h0, s_reg.uv};
		else if (ra == vj_pkg::A_STAT)
			rd = {26'h0, GROUP_I, s_reg.uvb, s_reg.lvl[0], s_reg.lvl[1], s_reg.cond};
		else if (ra == vj_pkg::A_CNTA)
			rd = {16'h0, s_reg.cnt_a};
		else if (ra == vj_pkg::A_CNTT)
			rd = {16'h0, s_reg.cnt_t};
		else if (ra == vj_pkg::A_CNTB)
			rd = {16'h0, s_reg.cnt_b};
		else if (ra[7:4] == vj_pkg::A_THR[7:4] && int'(ra[3]) < vj_pkg::NGRP)
			rd = {18'h0, ra[2] ? s_reg.thr_a[ra[3]] : s_reg.thr_t[ra[3]]};
		else if (ra[7:4] == vj_pkg::A_DIFF[7:4])
			rd = {{15{dif[ra[3:2]][16]}}, dif[ra[3:2]]};
		else if (ra[7:4] == vj_pkg::A_RATIO[7:4])
			rd = {16'h0, rat[ra[3:2]]};
		s_next.rdata = (acc && !HWRITE_I) ? rd : s_reg.rdata;

		// Bus write, data phase; group-independent settings live apart
		if (s_reg.wr_pend) begin
			if (s_reg.wr_addr == vj_pkg::A_CTRL) begin
				s_next.stage = HWDATA_I[vj_pkg::C_STAGE];
				if (HWDATA_I[vj_pkg::C_CHAN +: 4] <= 4'(vj_pkg::SEL_U4))
					s_next.chan = vj_pkg::chan_sel_t'(HWDATA_I[vj_pkg::C_CHAN +: 4]);
				s_next.frc = vj_pkg::cond_t'(HWDATA_I[vj_pkg::C_FORCE +: 2]);
				if (s_reg.allow && HWDATA_I[vj_pkg::C_NODE +: 3] <= 3'(vj_pkg::NODE_OFF))
					s_next.node = vj_pkg::node_t'(HWDATA_I[vj_pkg::C_NODE +: 3]);
			end
			if (s_reg.wr_addr == vj_pkg::A_GLOB) begin
				s_next.force_en = HWDATA_I[vj_pkg::G_FORCE];
				s_next.allow = HWDATA_I[vj_pkg::G_ALLOW];
			end
			if (s_reg.wr_addr == vj_pkg::A_NOM)
				s_next.nom = HWDATA_I[15:0];
			if (s_reg.wr_addr == vj_pkg::A_UV)
				s_next.uv = clamp(HWDATA_I, vj_pkg::UV_MIN, vj_pkg::UV_MAX);
			if (s_reg.wr_addr[7:4] == vj_pkg::A_THR[7:4]
				&& int'(s_reg.wr_addr[3]) < vj_pkg::NGRP) begin
				if (s_reg.wr_addr[2])
					s_next.thr_a[s_reg.wr_addr[3]] =
						clamp(HWDATA_I, vj_pkg::THR_MIN, vj_pkg::THR_MAX);
				else
					s_next.thr_t[s_reg.wr_addr[3]] =
						clamp(HWDATA_I, vj_pkg::THR_MIN, vj_pkg::THR_MAX);
			end
		end

		// Decision once per sample, one cycle after the trackers update
		s_next.smp_d = SAMPLE_I;
		if (SAMPLE_I) begin
			s_next.blk = BLOCK_I;
			s_next.stamp = s_reg.stamp + 32'h1;
		end
		if (s_reg.smp_d) begin
			s_next.uvb = uv_any;
			if (s_reg.force_en && s_reg.frc != vj_pkg::COND_NORMAL)
				nc = s_reg.frc;
			else if (s_reg.node == vj_pkg::NODE_OFF)
				nc = vj_pkg::COND_NORMAL;
			else if (s_reg.node == vj_pkg::NODE_BLOCKED
				|| s_reg.node == vj_pkg::NODE_TEST_BLOCKED || uv_any)
				nc = vj_pkg::COND_BLOCKED;
			else if (pick_t || pick_a)
				nc = s_reg.blk ? vj_pkg::COND_BLOCKED
					: (pick_t ? vj_pkg::COND_TRIP : vj_pkg::COND_ALARM);
			else
				nc = vj_pkg::COND_NORMAL;
			s_next.cond = nc;
		end

		// Single instantaneous stage: fixed pulse, no reset needed
		if (s_reg.smp_d && nc == vj_pkg::COND_TRIP && s_reg.tmr == 19'h0)
			s_next.tmr = TRIP_CYCLES;
		else if (s_reg.tmr != 19'h0)
			s_next.tmr = s_reg.tmr - 19'h1;

		nl[0] = s_next.cond == vj_pkg::COND_ALARM && s_reg.stage;
		nl[1] = s_next.tmr != 19'h0;
		nl[2] = s_next.cond == vj_pkg::COND_BLOCKED;
		s_next.lvl = nl;
		s_next.on = nl & ~s_reg.lvl;
		s_next.off = ~nl & s_reg.lvl;
		// Test mode keeps status and events but holds the trip and alarm outputs quiet
		s_next.trip = nl[1] && s_reg.node != vj_pkg::NODE_TEST;
		s_next.alarm = nl[0] && s_reg.node != vj_pkg::NODE_TEST;

		// Counters: a write clears, a same-cycle event still counts
		s_next.cnt_a = cnt_upd(s_reg.cnt_a, s_next.on[0],
			s_reg.wr_pend && s_reg.wr_addr == vj_pkg::A_CNTA);
		s_next.cnt_t = cnt_upd(s_reg.cnt_t, s_next.on[1],
			s_reg.wr_pend && s_reg.wr_addr == vj_pkg::A_CNTT);
		s_next.cnt_b = cnt_upd(s_reg.cnt_b, s_next.on[2],
			s_reg.wr_pend && s_reg.wr_addr == vj_pkg::A_CNTB);
	end

	function automatic logic [13:0] clamp(input logic [31:0] v, input logic [13:0] lo,
		input logic [13:0] hi);
		if (v < 32'(lo))
			return lo;
		if (v > 32'(hi))
			return hi;
		return v[13:0];
	endfunction

	function automatic logic [15:0] cnt_upd(input logic [15:0] c, input logic ev,
		input logic clr);
		if (clr)
			return ev ? 16'h1 : 16'h0;
		return ev ? c + 16'h1 : c;
	endfunction

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			s_reg <= '0;
			s_reg.chan <= vj_pkg::SEL_ANY_PP;
			s_reg.frc <= vj_pkg::COND_NORMAL;
			s_reg.node <= vj_pkg::NODE_ON;
			s_reg.cond <= vj_pkg::COND_NORMAL;
			s_reg.nom <= vj_pkg::NOM_RST;
			s_reg.uv <= vj_pkg::UV_RST;
			s_reg.thr_t <= {vj_pkg::NGRP{vj_pkg::THR_RST}};
			s_reg.thr_a <= {vj_pkg::NGRP{vj_pkg::THR_RST}};
		end else begin
			s_reg <= s_next;
		end
	end

	assign HRDATA_O    = s_reg.rdata;
	assign HREADYOUT_O = s_reg.ready;
	assign HRESP_O     = 1'b0;
	assign TRIP_O      = s_reg.trip;
	assign ALARM_O     = s_reg.alarm;
	assign BLOCKED_O   = s_reg.lvl[2];
	assign EVT_ON_O    = s_reg.on;
	assign EVT_OFF_O   = s_reg.off;
	assign EVT_STAMP_O = s_reg.stamp;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_trip_start: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		$rose(s_reg.lvl[1]) |-> s_reg.tmr == TRIP_CYCLES)
		else $error("trip pulse did not start at full length");
	a_trip_end: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		s_reg.tmr == 19'h1 |=> !s_reg.lvl[1] && !TRIP_O)
		else $error("trip pulse did not drop at end");
	a_block_wins: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		s_reg.smp_d && s_reg.blk && pick_t && !s_reg.force_en
		&& s_reg.node == vj_pkg::NODE_ON |=> s_reg.cond == vj_pkg::COND_BLOCKED)
		else $error("block at pick-up not reported");
	a_uv_blocks: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		s_reg.smp_d && uv_any && !s_reg.force_en && s_reg.node == vj_pkg::NODE_ON
		|=> s_reg.cond == vj_pkg::COND_BLOCKED ##1 BLOCKED_O)
		else $error("undervoltage did not block");
	a_no_pickup: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		s_reg.smp_d && !pick_t && !pick_a && !uv_any && !s_reg.force_en
		&& s_reg.node == vj_pkg::NODE_ON |=> s_reg.cond == vj_pkg::COND_NORMAL)
		else $error("condition set without pick-up");
	a_alarm_gated: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		ALARM_O |-> $past(s_reg.stage))
		else $error("alarm while alarm stage disabled");
	a_force_trip: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		s_reg.smp_d && s_reg.force_en && s_reg.frc == vj_pkg::COND_TRIP
		|=> s_reg.cond == vj_pkg::COND_TRIP)
		else $error("forced trip not applied");
	a_trip_count: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		s_next.on[1] && !(s_reg.wr_pend && s_reg.wr_addr == vj_pkg::A_CNTT)
		|=> s_reg.cnt_t == 16'($past(s_reg.cnt_t) + 16'h1) && EVT_ON_O[1])
		else $error("trip event not counted");
	a_thr_range: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		thr_t >= vj_pkg::THR_MIN && thr_t <= vj_pkg::THR_MAX)
		else $error("trip threshold out of range");
	a_node_locked: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		!s_reg.allow |=> $stable(s_reg.node))
		else $error("node state changed while locked");
	a_tmr_count: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		s_reg.tmr != 19'h0 |=> s_reg.tmr == 19'($past(s_reg.tmr) - 19'h1))
		else $error("trip timer restarted or stalled");
	a_trip_off_evt: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		$fell(s_reg.lvl[1]) |-> EVT_OFF_O[1])
		else $error("trip off event missing");
	a_stamp_step: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		SAMPLE_I |=> EVT_STAMP_O == 32'($past(EVT_STAMP_O) + 32'h1))
		else $error("time stamp did not advance on sample");
	a_test_quiet: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		s_reg.node == vj_pkg::NODE_TEST |=> !TRIP_O && !ALARM_O)
		else $error("output active in test state");
endmodule

// ===== test/front_end_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Sampling front end, one strobe every 8 clocks
// ----------------------------------------
module front_end_model (
	input  wire logic        clk_i,   // Clock
	input  wire logic        rst_n_i, // Sync reset, low
	input  wire logic        jump_i,  // Select rotated phasor
	output logic             smp_o,   // Sample strobe
	output logic [3:0][15:0] re_o,    // Real parts
	output logic [3:0][15:0] im_o     // Imaginary parts
);
	logic [2:0]  div;
	logic [15:0] re_v;
	logic [15:0] im_v;
	logic        fire;
	assign re_v = jump_i ? 16'h3f07 : 16'h4000;
	assign im_v = jump_i ? 16'h0b1d : 16'h0000;
	assign fire = rst_n_i && div == 3'h7;
	always @(posedge clk_i) begin
		div   <= rst_n_i ? div + 3'h1 : 3'h0;
		smp_o <= fire;
		// Junk between strobes so stale data never looks valid
		re_o  <= {4{fire ? re_v : ~re_v}};
		im_o  <= {4{fire ? im_v : ~im_v}};
	end
endmodule

// ===== test/voltage_vector_jump_detector_bench.sv
`timescale 1ns/1ps
module voltage_vector_jump_detector_bench;
	// ----------------------------------------
	// Bench signals and tasks
	// ----------------------------------------
	logic             ref_clk;
	logic             rst_n;
	logic             hsel;
	logic [31:0]      haddr;
	logic [1:0]       htrans;
	logic             hwrite;
	logic [31:0]      hwdata;
	logic [31:0]      hrdata;
	logic             hreadyout;
	logic             smp;
	logic [3:0][15:0] re;
	logic [3:0][15:0] im;
	logic             jmp;
	logic             block;
	logic             group;
	logic             trip;
	logic             alarm;
	logic             blocked;
	logic [2:0]       outs;
	logic             trip_seen;
	logic [31:0]      q;
	logic [2:0]       evt_on;
	logic [2:0]       evt_off;
	logic [31:0]      stamp;
	logic [31:0]      s0;
	logic             trip_d;
	int               n_on;
	int               n_off;
	int               n_rise;
	int               miscompares;
	int               n_tests;
	int               n;
	logic [7:0]       ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h24, 8'h28, 8'h2c};
	logic [31:0]      rv [8] = '{32'h10, 32'h0, 32'h4000, 32'h251c, 32'h1f4, 32'h1f4,
		32'h1f4, 32'h1f4};
	assign outs = {blocked, alarm, trip};
	always #25 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (trip === 1'b1) trip_seen <= 1'b1;
	always @(negedge ref_clk) begin
		trip_d <= trip;
		if (evt_on[1] === 1'b1) n_on <= n_on + 1;
		if (evt_off[1] === 1'b1) n_off <= n_off + 1;
		if (trip === 1'b1 && trip_d === 1'b0) n_rise <= n_rise + 1;
	end

	front_end_model fe_u (.clk_i(ref_clk), .rst_n_i(rst_n), .jump_i(jmp), .smp_o(smp),
		.re_o(re), .im_o(im));
	vector_jump #(.TRIP_CYCLES(19'h00014)) dut_u (.REF_CLK_I(ref_clk), .RST_N_I(rst_n),
		.HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
		.HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata),
		.HREADYOUT_O(hreadyout), .HRESP_O(), .SAMPLE_I(smp), .CH_RE_I(re), .CH_IM_I(im),
		.BLOCK_I(block), .GROUP_I(group), .TRIP_O(trip), .ALARM_O(alarm),
		.BLOCKED_O(blocked), .EVT_ON_O(evt_on), .EVT_OFF_O(evt_off), .EVT_STAMP_O(stamp));

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do begin @(posedge ref_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do begin @(posedge ref_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
		q = hrdata;
		if (k >= 50) begin
			miscompares++;
			summarize();
		end
		@(posedge ref_clk);
	endtask
	task automatic waitsig(input int k, input logic v);
		n = 0;
		do begin @(negedge ref_clk); n++; end while (outs[k] !== v && n < 3000);
		if (n >= 3000) begin
			miscompares++;
			summarize();
		end
		@(posedge ref_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		ref_clk = 0; rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
		jmp = 0; block = 0; group = 0; trip_seen = 0; miscompares = 0; n_tests = 0;
		n_on = 0; n_off = 0; n_rise = 0; trip_d = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			bus(0, ra[i], 0);
			chk("reset_value", rv[i], q);
		end
		bus(0, 8'h80, 0);
		chk("unmapped", 32'h0, q);
		bus(1, 8'h28, 32'h1);
		bus(0, 8'h28, 0);
		chk("thr_low_clamp", 32'h5, q);
		bus(1, 8'h2c, 32'hffff);
		bus(0, 8'h2c, 0);
		chk("thr_high_clamp", 32'hbb8, q);
		bus(1, 8'h00, 32'h4010);
		bus(0, 8'h00, 0);
		chk("node_locked", 32'h10, q);
		@(negedge ref_clk);
		s0 = stamp;
		repeat (64) @(negedge ref_clk);
		chk("stamp_rate", 32'h8, stamp - s0);
		// History must fill before any jump is meaningful
		repeat (600) @(posedge ref_clk);
		jmp <= 1'b1;
		waitsig(0, 1'b1);
		n = 0;
		do begin @(negedge ref_clk); n++; end while (trip === 1'b1 && n < 1000);
		@(posedge ref_clk);
		chk("trip_len", 32'h14, n);
		bus(0, 8'h30, 0);
		chk("jump_range", 32'h1, {31'h0, q >= 32'h3b6 && q <= 32'h41a});
		bus(0, 8'h18, 0);
		chk("trip_count", 32'h1, {31'h0, q != 32'h0});
		repeat (600) @(posedge ref_clk);
		chk("trip_on_events", n_rise, n_on);
		chk("trip_off_events", n_on, n_off);
		bus(0, 8'h18, 0);
		chk("trip_counter", n_on, q);
		bus(1, 8'h28, 32'hbb8);
		bus(1, 8'h2c, 32'h1f4);
		bus(1, 8'h00, 32'h11);
		group <= 1'b1;
		trip_seen = 1'b0;
		jmp <= 1'b0;
		waitsig(1, 1'b1);
		chk("no_trip_alarm", 32'h0, {31'h0, trip_seen});
		repeat (600) @(posedge ref_clk);
		group <= 1'b0;
		bus(1, 8'h00, 32'h10);
		block <= 1'b1;
		trip_seen = 1'b0;
		jmp <= 1'b1;
		waitsig(2, 1'b1);
		chk("no_trip_block", 32'h0, {31'h0, trip_seen});
		repeat (600) @(posedge ref_clk);
		block <= 1'b0;
		bus(1, 8'h08, 32'hffff);
		waitsig(2, 1'b1);
		bus(1, 8'h08, 32'h4000);
		waitsig(2, 1'b0);
		bus(1, 8'h04, 32'h1);
		bus(1, 8'h00, 32'h210);
		waitsig(0, 1'b1);
		bus(1, 8'h04, 32'h3);
		bus(1, 8'h00, 32'h2210);
		trip_seen = 1'b0;
		repeat (100) @(posedge ref_clk);
		chk("test_quiet", 32'h0, {31'h0, trip_seen});
		bus(0, 8'h10, 0);
		chk("test_status", 32'h2, {30'h0, q[1:0]});
		summarize();
	end
endmodule
